// ===== shared/sitc_pkg.sv
// Purpose: constants and carriers for the scan interval timer/counter
// Assumes: 100 MHz system clock, host bus with 15-bit byte address
// Notes:   counter window decodes on address bits 14:3, counter select on 2:1
`default_nettype none
package sitc_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int         CLK_HZ    = 100_000_000;
	localparam int         TIMER_HZ  = 6_250_000;
	localparam int         TICK_DIV  = CLK_HZ / TIMER_HZ;
	localparam logic [3:0] TICK_LAST = 4'(TICK_DIV - 1);
	// ****************************************
	// address map (byte offsets)
	// ****************************************
	localparam logic [14:0] OFS_TMR0   = 15'h0020;
	localparam logic [14:0] OFS_TMR1   = 15'h0022;
	localparam logic [14:0] OFS_WCNT   = 15'h0024;
	localparam logic [14:0] OFS_CTRL   = 15'h0026;
	localparam logic [14:0] OFS_BUF_LO = 15'h0080;
	localparam logic [14:0] OFS_BUF_HI = 15'h087E;
	localparam logic [14:0] OFS_SCR_LO = 15'h0880;
	localparam logic [14:0] OFS_SCR_HI = 15'h7FFE;
	localparam logic [11:0] CTR_WIN    = 12'h004;
	localparam logic [13:0] BUF_WORD   = 14'h0040;
	localparam int          RAM_WORDS  = 16384;
	// ****************************************
	// control word codes and fields
	// ****************************************
	localparam logic [7:0]  CW_LOAD_T0  = 8'h34;
	localparam logic [7:0]  CW_T1_RPT   = 8'h74;
	localparam logic [7:0]  CW_T1_ONE   = 8'h78;
	localparam logic [7:0]  CW_LOAD_DC  = 8'hB4;
	localparam logic [7:0]  CW_LATCH_T0 = 8'h00;
	localparam logic [7:0]  CW_LATCH_T1 = 8'h40;
	localparam logic [7:0]  CW_LATCH_DC = 8'h80;
	localparam logic [1:0]  CW_RW_LATCH = 2'h0;
	localparam logic [2:0]  CW_MODE_ONE = 3'h4;
	localparam logic [1:0]  CTR_IDX_CW  = 2'h3;
	localparam logic [7:0]  RD_UPPER    = 8'hFF;
	localparam logic [15:0] RD_NONE     = 16'hFFFF;
	localparam logic [15:0] CNT_ONE     = 16'h0001;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic        sel;
		logic        wr;
		logic [14:0] addr;
		logic [15:0] wdata;
	} sitc_req_s;
	typedef struct packed {
		logic       intervalEnable; // board control/status D13
		logic       cascade;        // board control/status D11
		logic       scanModeHi;     // channel setup D07
		logic       scanModeLo;     // channel setup D06
		logic       countSource;    // channel setup D10
		logic [2:0] irqLevel;       // irq level select
	} sitc_cfg_s;
	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic [15:0] latchVal;
		logic [7:0]  lowByte;
		logic        wrHi;
		logic        rdHi;
		logic        latched;
		logic        armed;
		logic        oneShot;
	} sitc_cnt_s;
endpackage
`default_nettype wire

// ===== src/sitc_timer_counter.sv
// Purpose: triple 16-bit timer/counter with sample buffer and scratch RAM
// Assumes: host bus and sample store are on clk; cfg bits held steady
// Notes:   host accesses to RAM stall one cycle against a sample store
//          counter reads return ones in the upper byte
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - timer0 on 6.25 MHz, timer1 on timer0
// - data counter counts stored words only
// - byte-wide accesses, low byte then high
// - four counter locations, control write only
// - data counter counts down, readable anytime
// - source bit swaps scan irq for count
// - burst when D7=1, D6=0, D13=1
// - interval expiry starts one buffer scan
// - D11 clear: timer0 alone sets interval
// - D11 set: timer1 counts timer0 outputs
// - load codes 34, 74/78, B4
// - latch, select, read low, read high
// - 74 repeats, 78 fires once until reload
// - cascade interval is timer0 period times timer1 count
// - sample buffer of 16-bit words
// - host scratch RAM untouched by scans
// - level field picks irq line, zero off
module sitc_timer_counter
	import sitc_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// host bus
	input  wire sitc_req_s   hostReq,
	output logic             hostAck,
	output logic             hostRvalid,
	output logic [15:0]      hostRdata,
	// board configuration bits
	input  wire sitc_cfg_s   cfg,
	// sample store from sequencer
	input  wire logic        storeValid,
	input  wire logic [9:0]  storeAddr,
	input  wire logic [15:0] storeData,
	// scan events
	input  wire logic        scanEndEvt,
	input  wire logic        irqAck,
	output logic             scanTrig,
	output logic [7:1]       irqLine
);
	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [3:0]      div;
		sitc_cnt_s [2:0] cnt;
		logic [15:0]     rdata;
		logic            rdRam;
		logic            rvalid;
		logic            scanTrig;
		logic            pending;
		logic [7:1]      irqLine;
	} sitc_state_s;

	sitc_state_s s_q;
	sitc_state_s s_d;
	logic [15:0] mem [RAM_WORDS];
	logic [15:0] ramRd_q;
	logic        tick;
	logic        t0Out;
	logic        t1Out;
	logic        dcZero;
	logic        expire;
	logic        burst;
	logic        inRam;
	logic        inCtr;
	logic        take;
	logic [1:0]  idx;
	logic [15:0] rv;
	logic [15:0] rc;

	// counter value as seen by a read, latched copy first
	function automatic logic [15:0] readVal(input sitc_cnt_s c);
		return c.latched ? c.latchVal : c.count;
	endfunction

	// ****************************************
	// decode
	// ****************************************
	assign inRam   = hostReq.addr >= OFS_BUF_LO && hostReq.addr <= OFS_SCR_HI
	                 && !hostReq.addr[0];
	assign inCtr   = hostReq.addr[14:3] == CTR_WIN;
	assign idx     = hostReq.addr[2:1];
	assign hostAck = hostReq.sel && !(storeValid && inRam);
	assign take    = hostAck;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		s_d      = s_q;
		tick     = 1'b0;
		t0Out    = 1'b0;
		t1Out    = 1'b0;
		dcZero   = 1'b0;
		rv       = RD_NONE;
		rc       = '0;
		// 6.25 MHz enable from the system clock
		if (s_q.div == TICK_LAST) begin
			s_d.div = '0;
			tick    = 1'b1;
		end else begin
			s_d.div = s_q.div + 4'h1;
		end
		// timer0 rate generator
		if (tick && s_q.cnt[0].armed) begin
			if (s_q.cnt[0].count == CNT_ONE) begin
				t0Out            = 1'b1;
				s_d.cnt[0].count = s_q.cnt[0].reload;
			end else begin
				s_d.cnt[0].count = s_q.cnt[0].count - CNT_ONE;
			end
		end
		// timer1 clocked by timer0 output
		if (t0Out && s_q.cnt[1].armed) begin
			if (s_q.cnt[1].count == CNT_ONE) begin
				t1Out            = 1'b1;
				s_d.cnt[1].count = s_q.cnt[1].reload;
				if (s_q.cnt[1].oneShot) begin
					s_d.cnt[1].armed = 1'b0;
				end
			end else begin
				s_d.cnt[1].count = s_q.cnt[1].count - CNT_ONE;
			end
		end
		// data counter steps down per stored word
		if (storeValid && s_q.cnt[2].armed) begin
			dcZero           = s_q.cnt[2].count == CNT_ONE;
			s_d.cnt[2].count = s_q.cnt[2].count - CNT_ONE;
		end
		// interval selection and timed-burst trigger
		expire       = cfg.cascade ? t1Out : t0Out;
		burst        = cfg.scanModeHi && !cfg.scanModeLo && cfg.intervalEnable;
		s_d.scanTrig = burst && expire;
		// host access to the counter window
		s_d.rvalid = take && !hostReq.wr;
		s_d.rdRam  = take && !hostReq.wr && inRam;
		if (take && inCtr && hostReq.wr) begin
			if (idx == CTR_IDX_CW) begin
				for (int i = 0; i < 3; i++) begin
					if (hostReq.wdata[7:6] == 2'(i)) begin
						if (hostReq.wdata[5:4] == CW_RW_LATCH) begin
							if (!s_q.cnt[i].latched) begin
								s_d.cnt[i].latched  = 1'b1;
								s_d.cnt[i].latchVal = s_q.cnt[i].count;
							end
						end else begin
							s_d.cnt[i].wrHi    = 1'b0;
							s_d.cnt[i].rdHi    = 1'b0;
							s_d.cnt[i].armed   = 1'b0;
							s_d.cnt[i].oneShot = hostReq.wdata[3:1] == CW_MODE_ONE;
						end
					end
				end
			end else if (!s_q.cnt[idx].wrHi) begin
				s_d.cnt[idx].lowByte = hostReq.wdata[7:0];
				s_d.cnt[idx].wrHi    = 1'b1;
			end else begin
				s_d.cnt[idx].reload = {hostReq.wdata[7:0], s_q.cnt[idx].lowByte};
				s_d.cnt[idx].count  = {hostReq.wdata[7:0], s_q.cnt[idx].lowByte};
				s_d.cnt[idx].armed  = 1'b1;
				s_d.cnt[idx].wrHi   = 1'b0;
			end
		end
		// host read of a counter byte
		if (take && inCtr && !hostReq.wr && idx != CTR_IDX_CW) begin
			rc = readVal(s_q.cnt[idx]);
			rv = {RD_UPPER, s_q.cnt[idx].rdHi ? rc[15:8] : rc[7:0]};
			s_d.cnt[idx].rdHi = !s_q.cnt[idx].rdHi;
			if (s_q.cnt[idx].rdHi) begin
				s_d.cnt[idx].latched = 1'b0;
			end
		end
		if (take && !hostReq.wr) begin
			s_d.rdata = rv;
		end
		// interrupt source and level, set wins over acknowledge
		s_d.pending = ((cfg.countSource ? dcZero : scanEndEvt) && cfg.irqLevel != 3'h0)
		              || (s_q.pending && !irqAck);
		for (int l = 1; l < 8; l++) begin
			s_d.irqLine[l] = s_d.pending && cfg.irqLevel == 3'(l);
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// memory
	// ****************************************
	// buffer and scratch RAM, sample store has the port first
	always_ff @(posedge clk) begin
		if (storeValid) begin
			mem[BUF_WORD + 14'(storeAddr)] <= storeData;
		end else if (take && inRam && hostReq.wr) begin
			mem[hostReq.addr[14:1]] <= hostReq.wdata;
		end
		ramRd_q <= mem[hostReq.addr[14:1]];
	end

	// ****************************************
	// outputs
	// ****************************************
	// registered answers and events
	assign hostRvalid = s_q.rvalid;
	assign hostRdata  = s_q.rdRam ? ramRd_q : s_q.rdata;
	assign scanTrig   = s_q.scanTrig;
	assign irqLine    = s_q.irqLine;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_tick_spacing: assert property (tick |=> !tick [*8])
		else $error("timer tick spacing too short");
	a_burst_trigger: assert property (scanTrig |-> $past(burst && expire))
		else $error("scan trigger without burst expiry");
	a_single_interval: assert property (!cfg.cascade && burst && t0Out |=> scanTrig)
		else $error("timer0 expiry missed scan trigger");
	a_cascade_step: assert property (
		s_q.cnt[1].armed && s_d.cnt[1].count != s_q.cnt[1].count
		&& !(take && inCtr && hostReq.wr) |-> t0Out)
		else $error("timer1 stepped without timer0 output");
	a_oneshot_halt: assert property (t1Out && s_q.cnt[1].oneShot |=> !s_q.cnt[1].armed)
		else $error("one-shot timer1 kept running");
	a_count_down: assert property (
		storeValid && s_q.cnt[2].armed && !(take && inCtr && hostReq.wr)
		|=> s_q.cnt[2].count == $past(s_q.cnt[2].count) - CNT_ONE)
		else $error("data counter did not decrement");
	a_upper_ones: assert property (
		take && inCtr && !hostReq.wr |=> hostRvalid && hostRdata[15:8] == RD_UPPER)
		else $error("counter read upper byte not ones");
	a_source_mask: assert property (
		cfg.countSource && !dcZero && !s_q.pending |=> !s_q.pending)
		else $error("scan irq raised while count source set");
	a_level_zero: assert property (cfg.irqLevel == 3'h0 && !s_q.pending |=> irqLine == '0)
		else $error("irq line driven with level zero");
	a_byte_pair: assert property (
		take && inCtr && hostReq.wr && idx != CTR_IDX_CW && !s_q.cnt[idx].wrHi
		|-> s_d.cnt[idx].wrHi)
		else $error("low byte did not advance write pointer");
	a_byte_high: assert property (
		take && inCtr && hostReq.wr && idx != CTR_IDX_CW && s_q.cnt[idx].wrHi
		|-> s_d.cnt[idx].armed && !s_d.cnt[idx].wrHi)
		else $error("high byte did not arm counter");

	// timer pacing
	a_div_range: assert property (s_q.div <= TICK_LAST)
		else $error("tick divider out of range");
	a_t0_reload: assert property (
		t0Out && !(take && inCtr && hostReq.wr)
		|=> s_q.cnt[0].count == $past(s_q.cnt[0].reload))
		else $error("timer0 did not reload on expiry");

	// data counter and latch
	a_dc_hold: assert property (
		!storeValid && !(take && inCtr && hostReq.wr) |=> $stable(s_q.cnt[2].count))
		else $error("data counter moved without a stored word");
	a_latch_freeze: assert property (
		s_q.cnt[2].latched && !(take && inCtr) |=> $stable(s_q.cnt[2].latchVal))
		else $error("latched count changed before read");

	// interrupt request
	a_count_event: assert property (
		cfg.countSource && cfg.irqLevel != 3'h0 && dcZero |=> s_q.pending)
		else $error("count event did not raise irq");
	a_irq_hold: assert property (s_q.pending && !irqAck |=> s_q.pending)
		else $error("irq dropped without acknowledge");

	// host bus answers
	a_store_wins: assert property (
		hostReq.sel && storeValid && inRam |-> !hostAck)
		else $error("host taken during sample store");
	a_read_answer: assert property (take && !hostReq.wr |=> hostRvalid)
		else $error("read not answered next cycle");
	a_no_answer: assert property (!(take && !hostReq.wr) |=> !hostRvalid)
		else $error("read answer without a read");
	a_ctrl_read: assert property (
		take && inCtr && idx == CTR_IDX_CW && !hostReq.wr |=> hostRdata == RD_NONE)
		else $error("control location read not all ones");

	c_burst: cover property (burst && expire ##1 scanTrig);
	c_cascade: cover property (cfg.cascade && t1Out);
	c_count_irq: cover property (cfg.countSource && dcZero ##1 s_q.pending);
	c_oneshot: cover property (t1Out && s_q.cnt[1].oneShot);
	c_store_stall: cover property (hostReq.sel && storeValid && inRam);
endmodule
`default_nettype wire

// ===== dv/sitc_host_model.sv
// Purpose: host bus master model for the timer/counter block
// Assumes: one access at a time, held until taken
// Notes:   released lines show the inverse of the last access
`timescale 1ns/10ps
`default_nettype none
module sitc_host_model
	import sitc_pkg::*;
(
	// clock
	input  wire logic        clk,
	// host bus
	output sitc_req_s        req,
	input  wire logic        ack,
	input  wire logic        rvalid,
	input  wire logic [15:0] rdata
);
	// idle bus at time zero
	initial req = '{1'b0, 1'b0, 15'h7FFF, 16'hFFFF};

	// one access: hold until ack at an edge, then release
	task automatic xfer(input logic w, input logic [14:0] a, input logic [15:0] d,
		output logic [15:0] q);
		int n;
		n = 0;
		q = 'x;
		@(posedge clk);
		#1;
		req = '{1'b1, w, a, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		#1;
		req = '{1'b0, ~w, ~a, ~d};
		if (!w && rvalid === 1'b1) q = rdata; // read data stands this cycle
	endtask
endmodule
`default_nettype wire

// ===== dv/sitc_timer_counter_tb.sv
// Purpose: self-checking bench for sitc_timer_counter
// Assumes: host model drives the bus side
// Notes:   timer tick is TICK_DIV clocks
`timescale 1ns/10ps
`default_nettype none
module sitc_timer_counter_tb
	import sitc_pkg::*;
;
	logic        clk, rstn, storeValid, scanEndEvt, irqAck, hostAck, hostRvalid, scanTrig;
	logic [15:0] hostRdata, storeData;
	logic [9:0]  storeAddr;
	logic [7:1]  irqLine;
	sitc_req_s   hostReq;
	sitc_cfg_s   cfg;
	int          error_cnt = 0;
	int          checked = 0;
	int          cyc = 0;

	// ********
	// harness
	// ********
	sitc_timer_counter uut (.clk(clk), .rstn(rstn), .hostReq(hostReq), .hostAck(hostAck),
		.hostRvalid(hostRvalid), .hostRdata(hostRdata), .cfg(cfg), .storeValid(storeValid),
		.storeAddr(storeAddr), .storeData(storeData), .scanEndEvt(scanEndEvt),
		.irqAck(irqAck), .scanTrig(scanTrig), .irqLine(irqLine));
	sitc_host_model host (.clk(clk), .req(hostReq), .ack(hostAck), .rvalid(hostRvalid),
		.rdata(hostRdata));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [14:0] a, input logic [15:0] d);
		logic [15:0] q;
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [14:0] a, input logic [15:0] e, input string nm);
		logic [15:0] q;
		host.xfer(1'b0, a, 16'h0000, q);
		chk(nm, e, q);
	endtask
	// control word, then low and high byte
	task automatic load(input logic [7:0] cw, input logic [14:0] a, input logic [15:0] v);
		wr(OFS_CTRL, {8'h00, cw});
		wr(a, {8'h00, v[7:0]});
		wr(a, {8'h00, v[15:8]});
	endtask
	// one-cycle pulse of {storeValid, irqAck, scanEndEvt}
	task automatic pulse(input logic [2:0] s);
		@(posedge clk);
		#1;
		{storeValid, irqAck, scanEndEvt} = s;
		@(posedge clk);
		#1;
		{storeValid, irqAck, scanEndEvt} = 3'h0;
	endtask
	task automatic store(input logic [9:0] a, input logic [15:0] d);
		storeAddr = a;
		storeData = d;
		pulse(3'h4);
	endtask
	task automatic trigs(input int k, output int n);
		n = 0;
		repeat (k) begin
			tick(1);
			if (scanTrig === 1'b1) n++;
		end
	endtask
	// clocks from one scan trigger to the next
	task automatic gap(output int n);
		int i;
		i = 0;
		n = 0;
		while (scanTrig !== 1'b1 && i < 3000) begin
			tick(1);
			i++;
		end
		do begin
			tick(1);
			n++;
		end while (scanTrig !== 1'b1 && n < 3000);
	endtask

	task automatic t_single();
		int n;
		logic [7:0] off [3] = '{8'h20, 8'hB0, 8'h80};
		cfg = sitc_cfg_s'(8'hA0);
		load(CW_LOAD_T0, OFS_TMR0, 16'h0003);
		gap(n);
		chk("t0 period", 16'(3 * TICK_DIV), 16'(n));
		foreach (off[i]) begin
			cfg = sitc_cfg_s'(off[i]);
			trigs(200, n);
			chk("burst off", 16'h0000, 16'(n));
		end
		$display("done single");
	endtask
	task automatic t_cascade();
		int n;
		cfg = sitc_cfg_s'(8'hE0);
		load(CW_LOAD_T0, OFS_TMR0, 16'h0002);
		load(CW_T1_RPT, OFS_TMR1, 16'h0003);
		gap(n);
		chk("cascade period", 16'(6 * TICK_DIV), 16'(n));
		repeat (2) begin
			load(CW_T1_ONE, OFS_TMR1, 16'h0002);
			trigs(600, n);
			chk("one shot", 16'h0001, 16'(n));
		end
		$display("done cascade");
	endtask
	task automatic t_count();
		cfg = sitc_cfg_s'(8'h0B);
		wr(OFS_SCR_LO, 16'h1234);
		load(CW_LOAD_DC, OFS_WCNT, 16'h0005);
		store(10'h000, 16'hA5C3);
		store(10'h001, 16'h5A3C);
		wr(OFS_CTRL, {8'h00, CW_LATCH_DC});
		wr(OFS_CTRL, {8'h00, CW_LOAD_DC});
		rd(OFS_WCNT, 16'hFF03, "count low");
		rd(OFS_WCNT, 16'hFF00, "count high");
		load(CW_LOAD_DC, OFS_WCNT, 16'h0002);
		store(10'h002, 16'h0F0F);
		store(10'h003, 16'hF0F0);
		tick(2);
		chk("count irq", 16'h0004, 16'(irqLine));
		pulse(3'h2);
		pulse(3'h1);
		tick(2);
		chk("scan irq masked", 16'h0000, 16'(irqLine));
		for (int lv = 0; lv < 8; lv++) begin
			cfg = sitc_cfg_s'(8'(lv));
			pulse(3'h1);
			tick(2);
			chk("irq line", 16'(lv ? 1 << (lv - 1) : 0), 16'(irqLine));
			pulse(3'h2);
		end
		// host read stalls behind a sample store to the same word
		fork
			store(10'h004, 16'hC0DE);
			rd(15'h0088, 16'hC0DE, "store first");
		join
		rd(OFS_SCR_LO, 16'h1234, "scratch");
		rd(OFS_BUF_LO, 16'hA5C3, "buffer");
		wr(OFS_BUF_HI, 16'hBE5A);
		rd(OFS_BUF_HI, 16'hBE5A, "buffer top");
		rd(OFS_CTRL, 16'hFFFF, "control read");
		$display("done count");
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// reset, then the scenarios
	initial begin
		rstn = 1'b0;
		cfg = '0;
		{storeValid, irqAck, scanEndEvt} = 3'h0;
		storeAddr = '0;
		storeData = '0;
		tick(6);
		rstn = 1'b1;
		t_single();
		t_cascade();
		t_count();
		finish_test();
	end
endmodule
`default_nettype wire
